// *** inc/ctb_pkg.sv ***
// package for the channel-four time base, compare and capture register block
// assumes one 16-bit register port clocked by sys_clk, no other clock
package ctb_pkg;

   // ==========================================================
   // bus widths
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 16;

   // ==========================================================
   // register offsets, byte addresses as printed
   localparam logic [11:0] OFS_TIMEBASE_LOW = 12'h310;
   localparam logic [11:0] OFS_TIMEBASE_HIGH = 12'h312;
   localparam logic [11:0] OFS_PERIOD_LOW = 12'h314;
   localparam logic [11:0] OFS_PERIOD_HIGH = 12'h316;
   localparam logic [11:0] OFS_PRIMARY_COMPARE = 12'h318;
   localparam logic [11:0] OFS_SECONDARY_COMPARE = 12'h31c;
   localparam logic [11:0] OFS_CAPTURE_BUFFER_LOW = 12'h320;
   localparam logic [11:0] OFS_CAPTURE_BUFFER_HIGH = 12'h322;
   localparam logic [11:0] OFS_CHANNEL_CONTROL = 12'h330;
   localparam logic [11:0] OFS_EVENT_STATUS = 12'h332;
   localparam logic [11:0] OFS_EVENT_MASK = 12'h334;

   // ==========================================================
   // channel control fields
   localparam int unsigned CTL_W = 5;
   localparam int unsigned CTL_ENABLE_BIT = 0;
   localparam int unsigned CTL_WIDE_BIT = 1;
   localparam int unsigned CTL_CAPSEL_BIT = 2;
   localparam int unsigned CTL_PRESC_LSB = 3;
   localparam logic [4:0] CTL_RESET = 5'h00;

   // ==========================================================
   // event status and mask fields
   localparam int unsigned EVT_W = 5;
   localparam int unsigned EVT_PERIOD_BIT = 0;
   localparam int unsigned EVT_PRIMARY_BIT = 1;
   localparam int unsigned EVT_SECONDARY_BIT = 2;
   localparam int unsigned EVT_CAPTURE_BIT = 3;
   localparam int unsigned EVT_OVERFLOW_BIT = 4;
   localparam int unsigned NOT_EMPTY_BIT = 5;
   localparam logic [4:0] EVT_RESET = 5'h00;

   // ==========================================================
   // data register reset values
   localparam logic [15:0] HALF_RESET = 16'h0000;

   // ==========================================================
   // prescaler terminal counts for 1:1, 1:4, 1:16, 1:64
   localparam logic [5:0] PRESC_TERM_1 = 6'h00;
   localparam logic [5:0] PRESC_TERM_4 = 6'h03;
   localparam logic [5:0] PRESC_TERM_16 = 6'h0f;
   localparam logic [5:0] PRESC_TERM_64 = 6'h3f;

   // ==========================================================
   // capture fifo shape
   localparam int unsigned FIFO_DEPTH = 4;
   localparam int unsigned PTR_W = 2;
   localparam logic [2:0] FIFO_FULL_LEVEL = 3'h4;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [11:0] addr;
      logic [15:0] wdata;
   } ctb_bus_req_t;

   typedef struct packed {
      logic period;
      logic primary;
      logic secondary;
   } ctb_match_t;

endpackage

// *** logic/ctb_regs.sv ***
// time base, period, two compare values and capture fifo of one channel
// assumes all inputs synchronous to sys_clk; capture_strobe is a one-cycle
// pulse from the edge logic outside this block
`timescale 1ns/1ns
`default_nettype none

module ctb_regs (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // register port
   input wire ctb_pkg::ctb_bus_req_t bus_req,
   output var logic [15:0] rd_data,
   // capture request
   input wire logic capture_strobe,
   // compare and period pulses
   output var ctb_pkg::ctb_match_t match_pulse,
   // interrupt
   output logic irq
);

   // ==========================================================
   // storage
   logic [31:0] count_reg;
   logic [31:0] count_next;
   logic [31:0] period_reg;
   logic [15:0] primary_reg;
   logic [15:0] secondary_reg;
   logic [4:0] ctl_reg;
   logic [4:0] status_reg;
   logic [4:0] status_next;
   logic [4:0] mask_reg;
   logic [5:0] presc_reg;
   logic [15:0] rd_data_reg;
   logic [31:0] fifo_mem [ctb_pkg::FIFO_DEPTH];
   logic [1:0] wr_ptr_reg;
   logic [1:0] rd_ptr_reg;
   logic [2:0] level_reg;

   // ==========================================================
   // decode
   logic wide;
   logic capsel;
   logic enable;
   logic wr_tb_low;
   logic wr_tb_high;
   logic wr_status;
   logic [5:0] presc_term;
   logic tick;
   logic [31:0] count_eff;
   logic [31:0] period_eff;
   logic at_period;
   logic prim_hit;
   logic sec_hit;
   logic period_hit;
   logic cap_take;
   logic fifo_full;
   logic push;
   logic pop;
   logic ovf_evt;
   logic [31:0] head;
   logic [4:0] events;
   logic [4:0] clear_bits;

   assign enable = ctl_reg[ctb_pkg::CTL_ENABLE_BIT];
   assign wide = ctl_reg[ctb_pkg::CTL_WIDE_BIT];
   assign capsel = ctl_reg[ctb_pkg::CTL_CAPSEL_BIT];
   assign wr_tb_low = bus_req.wr && bus_req.addr == ctb_pkg::OFS_TIMEBASE_LOW;
   assign wr_tb_high = bus_req.wr && bus_req.addr == ctb_pkg::OFS_TIMEBASE_HIGH;
   assign wr_status = bus_req.wr && bus_req.addr == ctb_pkg::OFS_EVENT_STATUS;

   always_comb begin
      case (ctl_reg[ctb_pkg::CTL_PRESC_LSB +: 2])
         2'h1: presc_term = ctb_pkg::PRESC_TERM_4;
         2'h2: presc_term = ctb_pkg::PRESC_TERM_16;
         2'h3: presc_term = ctb_pkg::PRESC_TERM_64;
         default: presc_term = ctb_pkg::PRESC_TERM_1;
      endcase
   end

   assign tick = enable && presc_reg == presc_term;

   // narrow mode ignores the upper halves entirely
   assign count_eff = wide ? count_reg : {16'h0000, count_reg[15:0]};
   assign period_eff = wide ? period_reg : {16'h0000, period_reg[15:0]};
   assign at_period = count_eff == period_eff;

   // compares are only live in compare/timer function
   assign prim_hit = tick && !capsel && count_reg[15:0] == primary_reg;
   assign sec_hit = tick && !capsel && count_reg[15:0] == secondary_reg;
   assign period_hit = tick && !capsel && at_period;

   // ==========================================================
   // capture fifo control
   assign cap_take = enable && capsel && capture_strobe;
   assign fifo_full = level_reg == ctb_pkg::FIFO_FULL_LEVEL;
   assign push = cap_take && !fifo_full;
   assign ovf_evt = cap_take && fifo_full;
   // empty buffer reads as zero rather than a stale or never-written entry
   assign head = (level_reg != 3'h0) ? fifo_mem[rd_ptr_reg] : 32'h0000_0000;
   // the half that completes a read pops, so a 32-bit read low-then-high sees one entry
   assign pop = bus_req.rd && level_reg != 3'h0 &&
                ((wide && bus_req.addr == ctb_pkg::OFS_CAPTURE_BUFFER_HIGH) ||
                 (!wide && bus_req.addr == ctb_pkg::OFS_CAPTURE_BUFFER_LOW));

   // ==========================================================
   // time base
   always_comb begin
      count_next = count_reg;
      if (wr_tb_low) begin
         count_next = {count_reg[31:16], bus_req.wdata};
      end else if (wr_tb_high) begin
         count_next = {bus_req.wdata, count_reg[15:0]};
      end else if (tick) begin
         if (at_period) begin
            count_next = wide ? 32'h0000_0000 : {count_reg[31:16], 16'h0000};
         end else if (wide) begin
            count_next = count_reg + 32'h0000_0001;
         end else begin
            count_next = {count_reg[31:16], count_reg[15:0] + 16'h0001};
         end
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         count_reg <= {ctb_pkg::HALF_RESET, ctb_pkg::HALF_RESET};
      end else begin
         count_reg <= count_next;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         presc_reg <= 6'h00;
      end else if (!enable || tick) begin
         presc_reg <= 6'h00;
      end else begin
         presc_reg <= presc_reg + 6'h01;
      end
   end

   // ==========================================================
   // period, compare and control registers
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         period_reg <= {ctb_pkg::HALF_RESET, ctb_pkg::HALF_RESET};
         primary_reg <= ctb_pkg::HALF_RESET;
         secondary_reg <= ctb_pkg::HALF_RESET;
         ctl_reg <= ctb_pkg::CTL_RESET;
         mask_reg <= ctb_pkg::EVT_RESET;
      end else if (bus_req.wr) begin
         case (bus_req.addr)
            ctb_pkg::OFS_PERIOD_LOW: period_reg[15:0] <= bus_req.wdata;
            ctb_pkg::OFS_PERIOD_HIGH: period_reg[31:16] <= bus_req.wdata;
            ctb_pkg::OFS_PRIMARY_COMPARE: primary_reg <= bus_req.wdata;
            ctb_pkg::OFS_SECONDARY_COMPARE: secondary_reg <= bus_req.wdata;
            ctb_pkg::OFS_CHANNEL_CONTROL: ctl_reg <= bus_req.wdata[4:0];
            ctb_pkg::OFS_EVENT_MASK: mask_reg <= bus_req.wdata[4:0];
            default: ;
         endcase
      end
   end

   // ==========================================================
   // capture fifo
   // no reset on the array; entries are only visible once pushed
   always_ff @(posedge sys_clk) begin
      if (push) begin
         fifo_mem[wr_ptr_reg] <= count_eff;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_ptr_reg <= 2'h0;
         rd_ptr_reg <= 2'h0;
         level_reg <= 3'h0;
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + 2'h1;
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + 2'h1;
         end
         if (push && !pop) begin
            level_reg <= level_reg + 3'h1;
         end else if (pop && !push) begin
            level_reg <= level_reg - 3'h1;
         end
      end
   end

   // ==========================================================
   // events and interrupt
   always_comb begin
      events = 5'h00;
      events[ctb_pkg::EVT_PERIOD_BIT] = period_hit;
      events[ctb_pkg::EVT_PRIMARY_BIT] = prim_hit;
      events[ctb_pkg::EVT_SECONDARY_BIT] = sec_hit;
      events[ctb_pkg::EVT_CAPTURE_BIT] = push;
      events[ctb_pkg::EVT_OVERFLOW_BIT] = ovf_evt;
   end

   assign clear_bits = wr_status ? bus_req.wdata[4:0] : 5'h00;
   // a new event in the clearing cycle survives
   assign status_next = (status_reg & ~clear_bits) | events;

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         status_reg <= ctb_pkg::EVT_RESET;
      end else begin
         status_reg <= status_next;
      end
   end

   assign irq = |(status_reg & mask_reg);

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         match_pulse <= '0;
      end else begin
         match_pulse.period <= period_hit;
         match_pulse.primary <= prim_hit;
         match_pulse.secondary <= sec_hit;
      end
   end

   // ==========================================================
   // read port, data valid only the cycle after the strobe
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_data_reg <= 16'h0000;
      end else if (!bus_req.rd) begin
         rd_data_reg <= 16'h0000;
      end else begin
         case (bus_req.addr)
            ctb_pkg::OFS_TIMEBASE_LOW: rd_data_reg <= count_reg[15:0];
            ctb_pkg::OFS_TIMEBASE_HIGH: rd_data_reg <= count_reg[31:16];
            ctb_pkg::OFS_PERIOD_LOW: rd_data_reg <= period_reg[15:0];
            ctb_pkg::OFS_PERIOD_HIGH: rd_data_reg <= period_reg[31:16];
            ctb_pkg::OFS_PRIMARY_COMPARE: rd_data_reg <= primary_reg;
            ctb_pkg::OFS_SECONDARY_COMPARE: rd_data_reg <= secondary_reg;
            ctb_pkg::OFS_CAPTURE_BUFFER_LOW: rd_data_reg <= head[15:0];
            ctb_pkg::OFS_CAPTURE_BUFFER_HIGH: rd_data_reg <= head[31:16];
            ctb_pkg::OFS_CHANNEL_CONTROL: rd_data_reg <= {11'h000, ctl_reg};
            ctb_pkg::OFS_EVENT_STATUS: rd_data_reg <= {10'h000, level_reg != 3'h0, status_reg};
            ctb_pkg::OFS_EVENT_MASK: rd_data_reg <= {11'h000, mask_reg};
            default: rd_data_reg <= 16'h0000;
         endcase
      end
   end

   assign rd_data = rd_data_reg;

   // ==========================================================
   // checks
   a_low_write: assert property (@(posedge sys_clk) disable iff (!reset_n)
      wr_tb_low |=> count_reg[15:0] == $past(bus_req.wdata))
      else $error("count low write lost");

   a_high_write: assert property (@(posedge sys_clk) disable iff (!reset_n)
      wr_tb_high |=> count_reg[31:16] == $past(bus_req.wdata))
      else $error("count high write lost");

   a_period_low: assert property (@(posedge sys_clk) disable iff (!reset_n)
      bus_req.wr && bus_req.addr == ctb_pkg::OFS_PERIOD_LOW ##1 !bus_req.wr ##1
      bus_req.rd && bus_req.addr == ctb_pkg::OFS_PERIOD_LOW
      |=> rd_data == $past(bus_req.wdata, 3))
      else $error("period low readback wrong");

   a_period_high: assert property (@(posedge sys_clk) disable iff (!reset_n)
      bus_req.wr && bus_req.addr == ctb_pkg::OFS_PERIOD_HIGH
      |=> period_reg[31:16] == $past(bus_req.wdata))
      else $error("period high write lost");

   a_primary_match: assert property (@(posedge sys_clk) disable iff (!reset_n)
      tick && !capsel && count_reg[15:0] == primary_reg
      |=> match_pulse.primary && status_reg[ctb_pkg::EVT_PRIMARY_BIT])
      else $error("primary match missed");

   a_secondary_match: assert property (@(posedge sys_clk) disable iff (!reset_n)
      tick && !capsel && count_reg[15:0] == secondary_reg
      |=> match_pulse.secondary && status_reg[ctb_pkg::EVT_SECONDARY_BIT])
      else $error("secondary match missed");

   a_buffer_low: assert property (@(posedge sys_clk) disable iff (!reset_n)
      bus_req.rd && bus_req.addr == ctb_pkg::OFS_CAPTURE_BUFFER_LOW
      |=> rd_data == $past(head[15:0]))
      else $error("buffer low not oldest entry");

   a_buffer_high: assert property (@(posedge sys_clk) disable iff (!reset_n)
      bus_req.rd && bus_req.addr == ctb_pkg::OFS_CAPTURE_BUFFER_HIGH
      |=> rd_data == $past(head[31:16]))
      else $error("buffer high not oldest entry");

   a_narrow_upper: assert property (@(posedge sys_clk) disable iff (!reset_n)
      !wide && !wr_tb_high |=> $stable(count_reg[31:16]))
      else $error("upper half moved in narrow mode");

   a_capsel_gate: assert property (@(posedge sys_clk) disable iff (!reset_n)
      !capsel && !pop |=> $stable(level_reg))
      else $error("capture taken in compare function");

   a_not_empty: assert property (@(posedge sys_clk) disable iff (!reset_n)
      bus_req.rd && bus_req.addr == ctb_pkg::OFS_EVENT_STATUS
      |=> rd_data[ctb_pkg::NOT_EMPTY_BIT] == ($past(level_reg) != 3'h0))
      else $error("not empty flag wrong");

   a_overflow_set: assert property (@(posedge sys_clk) disable iff (!reset_n)
      cap_take && fifo_full |=> status_reg[ctb_pkg::EVT_OVERFLOW_BIT] && $stable(wr_ptr_reg))
      else $error("overflow not flagged");

   a_pop_advance: assert property (@(posedge sys_clk) disable iff (!reset_n)
      pop && !push |=> level_reg == $past(level_reg) - 3'h1 &&
      rd_ptr_reg == $past(rd_ptr_reg) + 2'h1)
      else $error("read did not pop fifo");

   a_count_wrap: assert property (@(posedge sys_clk) disable iff (!reset_n)
      tick && at_period && wide && !wr_tb_low && !wr_tb_high
      |=> count_reg == 32'h0000_0000)
      else $error("count did not wrap after period");

   a_count_step: assert property (@(posedge sys_clk) disable iff (!reset_n)
      tick && !at_period && !wr_tb_low && !wr_tb_high
      |=> count_reg[15:0] == $past(count_reg[15:0]) + 16'h0001)
      else $error("count did not step");

endmodule

`default_nettype wire

// *** tb/ctb_testbench.sv ***
// self-checking bench for the channel time base, period, compare and capture registers
// assumes ctb_pkg is compiled first and that the block has one sys_clk domain
`timescale 1ns/1ns
`default_nettype none

module testbench;
   typedef struct {
      logic [15:0] v;
      string n;
   } ctb_note_t;

   logic sys_clk;
   logic reset_n;
   ctb_pkg::ctb_bus_req_t bus_req;
   logic capture_strobe;
   logic [15:0] rd_data;
   ctb_pkg::ctb_match_t match_pulse;
   logic irq;
   ctb_note_t notes[$];
   logic rd_prev;
   int miscompares;
   int check_count;
   logic [11:0] offs[12];
   logic [15:0] vals[6];
   logic [15:0] hi;
   int n;
   int s;

   ctb_regs dut (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .bus_req(bus_req),
      .rd_data(rd_data),
      .capture_strobe(capture_strobe),
      .match_pulse(match_pulse),
      .irq(irq)
   );

   // ==========================================================
   // clock
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   // ==========================================================
   // helpers
   task automatic fail(input string what, input logic [15:0] e, input logic [15:0] g);
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
   endtask

   task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
      check_count++;
      if (g !== e) begin
         fail(what, e, g);
      end
   endtask

   // a read leaves its expected data in the note queue for the monitor
   task automatic bus(input logic w, input logic [11:0] a, input logic [15:0] d, input string s);
      ctb_note_t t;
      if (!w) begin
         t.v = d;
         t.n = s;
         notes.push_back(t);
      end
      @(posedge sys_clk);
      bus_req <= '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge sys_clk);
      bus_req <= '{wr: 1'b0, rd: 1'b0, addr: a, wdata: d};
   endtask

   task automatic cap();
      @(posedge sys_clk);
      capture_strobe <= 1'b1;
      @(posedge sys_clk);
      capture_strobe <= 1'b0;
   endtask

   task automatic irq_is(input logic e);
      @(posedge sys_clk);
      #1;
      chk("irq", {15'h0000, e}, {15'h0000, irq});
   endtask

   // cycles until the chosen match pulse shows, bounded
   task automatic gap(input int sel, output int cnt);
      cnt = 0;
      do begin
         @(posedge sys_clk);
         #1;
         cnt++;
      end while (match_pulse[sel] !== 1'b1 && cnt < 2000);
   endtask

   function automatic logic [15:0] ctlv(input logic wide, input logic capf, input logic [1:0] p);
      return {11'h000, p, capf, wide, 1'b1};
   endfunction

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // ==========================================================
   // monitor: read data stands only in the cycle after the strobe
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_prev <= 1'b0;
      end else begin
         if (rd_prev === 1'b1) begin
            if (notes.size() == 0) begin
               fail("unexpected read", 16'h0000, rd_data);
            end else begin
               chk(notes[0].n, notes[0].v, rd_data);
               void'(notes.pop_front());
            end
         end else if (rd_data !== 16'h0000) begin
            fail("idle read data", 16'h0000, rd_data);
         end
         rd_prev <= bus_req.rd;
      end
   end

   // ==========================================================
   // watchdog, far beyond the 1200 or so cycles the tests need
   initial begin
      #200000;
      miscompares++;
      $display("CHECK FAILED watchdog expected done seen hang");
      give_verdict();
   end

   // ==========================================================
   // tests
   initial begin
      reset_n = 1'b0;
      bus_req = '0;
      capture_strobe = 1'b0;
      miscompares = 0;
      check_count = 0;
      offs = '{ctb_pkg::OFS_TIMEBASE_LOW, ctb_pkg::OFS_TIMEBASE_HIGH,
         ctb_pkg::OFS_PERIOD_LOW, ctb_pkg::OFS_PERIOD_HIGH, ctb_pkg::OFS_PRIMARY_COMPARE,
         ctb_pkg::OFS_SECONDARY_COMPARE, ctb_pkg::OFS_CAPTURE_BUFFER_LOW,
         ctb_pkg::OFS_CAPTURE_BUFFER_HIGH, ctb_pkg::OFS_CHANNEL_CONTROL,
         ctb_pkg::OFS_EVENT_STATUS, ctb_pkg::OFS_EVENT_MASK, 12'h3fe};
      repeat (6) @(posedge sys_clk);
      reset_n <= 1'b1;
      void'($urandom(32'h374eadcd));
      for (int i = 0; i < 12; i++) begin
         bus(1'b0, offs[i], 16'h0000, "reset value");
      end
      $display("test reset values done");
      for (int i = 0; i < 6; i++) begin
         vals[i] = 16'($urandom);
         bus(1'b1, offs[i], vals[i], "");
         bus(1'b0, offs[i], vals[i], "rw register");
      end
      // buffer and unmapped writes must leave no trace
      bus(1'b1, offs[6], 16'hffff, "");
      bus(1'b1, offs[11], 16'hffff, "");
      bus(1'b0, offs[6], 16'h0000, "buffer low after write");
      bus(1'b0, offs[11], 16'h0000, "unmapped after write");
      $display("test read write done");
      bus(1'b1, offs[0], 16'h0000, "");
      bus(1'b1, offs[1], 16'h0000, "");
      bus(1'b1, offs[2], 16'h0005, "");
      bus(1'b1, offs[3], 16'h0000, "");
      bus(1'b1, offs[4], 16'h0002, "");
      bus(1'b1, offs[5], 16'h0004, "");
      bus(1'b1, offs[10], 16'h0001, "");
      for (int p = 0; p < 4; p++) begin
         s = 1 << (2 * p);
         bus(1'b1, offs[8], ctlv(1'b0, 1'b0, 2'(p)), "");
         gap(2, n);
         gap(1, n);
         chk("period to primary", 16'(3 * s), 16'(n));
         gap(0, n);
         chk("primary to secondary", 16'(2 * s), 16'(n));
         gap(2, n);
         chk("secondary to period", 16'(s), 16'(n));
      end
      cap();
      bus(1'b1, offs[8], 16'h0000, "");
      irq_is(1'b1);
      bus(1'b0, offs[9], 16'h0007, "status after timer");
      bus(1'b1, offs[9], 16'h0007, "");
      bus(1'b0, offs[9], 16'h0000, "status after clear");
      irq_is(1'b0);
      $display("test timer compare done");
      // prescale 1:64 keeps the count still while the captures are taken
      hi = 16'($urandom);
      bus(1'b1, offs[2], 16'hffff, "");
      bus(1'b1, offs[3], 16'hffff, "");
      bus(1'b1, offs[1], hi, "");
      bus(1'b1, offs[8], ctlv(1'b1, 1'b1, 2'h3), "");
      for (int i = 0; i < 5; i++) begin
         vals[i] = 16'($urandom);
         bus(1'b1, offs[0], vals[i], "");
         cap();
      end
      bus(1'b0, offs[9], 16'h0038, "status after overflow");
      irq_is(1'b0);
      bus(1'b1, offs[10], 16'h0010, "");
      irq_is(1'b1);
      for (int i = 0; i < 4; i++) begin
         bus(1'b0, offs[6], vals[i], "buffer low");
         bus(1'b0, offs[7], hi, "buffer high");
      end
      bus(1'b0, offs[9], 16'h0018, "status after drain");
      bus(1'b1, offs[9], 16'h0018, "");
      irq_is(1'b0);
      $display("test wide capture done");
      bus(1'b1, offs[8], 16'h0000, "");
      bus(1'b1, offs[0], vals[5], "");
      bus(1'b1, offs[8], ctlv(1'b0, 1'b1, 2'h3), "");
      cap();
      bus(1'b0, offs[7], 16'h0000, "narrow buffer high");
      bus(1'b0, offs[6], vals[5], "narrow buffer low");
      bus(1'b0, offs[9], 16'h0008, "status after narrow");
      repeat (3) @(posedge sys_clk);
      $display("test narrow capture done");
      // wide timer: the low half must carry into the high half before the period hits
      bus(1'b1, offs[8], 16'h0000, "");
      bus(1'b1, offs[2], 16'h0003, "");
      bus(1'b1, offs[3], 16'h0001, "");
      bus(1'b1, offs[0], 16'hfffe, "");
      bus(1'b1, offs[1], 16'h0000, "");
      bus(1'b1, offs[8], ctlv(1'b1, 1'b0, 2'h0), "");
      gap(2, n);
      chk("wide period gap", 16'h0006, 16'(n));
      bus(1'b0, offs[1], 16'h0000, "wide count high after wrap");
      @(posedge sys_clk);
      $display("test wide timer done");
      // reset in mid-run must bring every register back
      reset_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      reset_n <= 1'b1;
      for (int i = 0; i < 12; i++) begin
         bus(1'b0, offs[i], 16'h0000, "value after reset");
      end
      $display("test mid-run reset done");
      give_verdict();
   end
endmodule

`default_nettype wire
